// file: logic/thi_pkg.sv
// Shared constants and types for the touch host I2C object port master.
// Assumes a 20 MHz core clock and an open-drain bus with external pull-ups.
package thi_pkg;

  // Device bus addresses selected by the device strap
  localparam logic [6:0] DEV_ADDR_LOW = 7'h4A;
  localparam logic [6:0] DEV_ADDR_HIGH = 7'h4B;

  // Checksum flag position in the pointer high byte
  localparam int PTR_FLAG_BIT = 7;

  // Ack bit values as driven on the ninth clock
  localparam logic BIT_ACK = 1'b0;
  localparam logic BIT_NACK = 1'b1;

  // Released level of an open-drain enable, used at reset
  localparam logic OE_RELEASE = 1'b1;
  localparam logic PIN_IDLE = 1'b1;

  // Bus timing: fast mode period, split into four quarters
  localparam int SCL_PERIOD_NS = 2500;
  localparam int CORE_PERIOD_NS = 50;
  localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * CORE_PERIOD_NS - 1) / (4 * CORE_PERIOD_NS);

  // Default checksum polynomial and seed
  localparam logic [7:0] CRC_POLY_DEF = 8'h07;
  localparam logic [7:0] CRC_INIT_DEF = 8'h00;

  // Transaction kinds offered to the user
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_MSGREAD = 2'b10
  } thi_op_e;

  // Bit engine operations and states
  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_START = 2'b01,
    E_STOP = 2'b10,
    E_BITS = 2'b11
  } thi_eng_e;

  // One user command
  typedef struct packed {
    thi_op_e op;
    logic [14:0] ptr;
    logic crc_en;
    logic [7:0] len;
    logic addr_high;
  } thi_cmd_s;

endpackage

// file: logic/thi_bit_engine.sv
// Bit-level I2C master engine: START, STOP and nine-bit byte slots.
// Assumes SDA arrives already synchronised and the caller waits for done.
`timescale 1ns/100ps
module thi_bit_engine import thi_pkg::*; #(
  parameter int QTR = QTR_CYCLES
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_req, // Start an operation
  input thi_eng_e i_op, // Operation kind
  input wire logic [8:0] i_tx, // Byte then ack bit, MSB first
  input wire logic i_sda, // Synchronised SDA level
  output logic o_done, // One-cycle completion pulse
  output logic [8:0] o_rx, // Sampled nine bits
  output logic o_line_lo, // Level driven when enabled
  output logic o_scl_oe_n, // SCL enable, low drives
  output logic o_sda_oe_n // SDA enable, low drives
);

  initial begin
    if (QTR < 2 || QTR > 255) $error("QTR out of range");
  end

  typedef struct packed {
    thi_eng_e st;
    logic [1:0] ph;
    logic [7:0] qc;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [8:0] rx;
    logic done;
    logic line_lo;
    logic scl_oe_n;
    logic sda_oe_n;
  } thi_eng_s;

  localparam thi_eng_s ENG_RST = '{st: E_IDLE, ph: 2'h0, qc: 8'h00, bitn: 4'h0,
    sh: 9'h1FF, rx: 9'h000, done: 1'b0, line_lo: 1'b0, scl_oe_n: OE_RELEASE,
    sda_oe_n: OE_RELEASE};
  localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

  thi_eng_s r_reg, r_next;
  logic tick;

  // Line levels for each quarter: {scl_oe_n, sda_oe_n}, 1 releases
  function automatic logic [1:0] lines(thi_eng_e st, logic [1:0] ph, logic b, logic scl);
    logic [1:0] v;
    v = 2'b11;
    unique case (st)
      E_START: v = (ph == 2'h0) ? {scl, 1'b1} : (ph == 2'h1) ? 2'b11 :
                   (ph == 2'h2) ? 2'b10 : 2'b00;
      E_STOP: v = (ph == 2'h0) ? 2'b00 : (ph == 2'h1) ? 2'b10 : 2'b11;
      E_BITS: v = {(ph == 2'h1 || ph == 2'h2), b};
      E_IDLE: v = {scl, 1'b1};
    endcase
    return v;
  endfunction

  // Quarter sequencer
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    tick = (r_reg.qc == QTR_LAST);
    unique case (r_reg.st)
      E_IDLE: begin
        if (i_req) begin
          r_next.st = i_op;
          r_next.ph = 2'h0;
          r_next.qc = 8'h00;
          r_next.bitn = 4'h0;
          r_next.sh = i_tx;
          {r_next.scl_oe_n, r_next.sda_oe_n} = lines(i_op, 2'h0, i_tx[8], r_reg.scl_oe_n);
        end
      end
      default: begin
        r_next.qc = tick ? 8'h00 : r_reg.qc + 8'h01;
        if (tick) begin
          // Sample at the end of the second of the two quarters that SCL is high
          if (r_reg.st == E_BITS && r_reg.ph == 2'h2) r_next.rx = {r_reg.rx[7:0], i_sda};
          if (r_reg.ph == 2'h3) begin
            if (r_reg.st != E_BITS || r_reg.bitn == 4'h8) begin
              r_next.st = E_IDLE;
              r_next.done = 1'b1;
            end else begin
              r_next.bitn = r_reg.bitn + 4'h1;
              r_next.sh = {r_reg.sh[7:0], 1'b1};
              r_next.ph = 2'h0;
              {r_next.scl_oe_n, r_next.sda_oe_n} = lines(E_BITS, 2'h0, r_reg.sh[7],
                                                          r_reg.scl_oe_n);
            end
          end else begin
            r_next.ph = r_reg.ph + 2'h1;
            {r_next.scl_oe_n, r_next.sda_oe_n} = lines(r_reg.st, r_reg.ph + 2'h1,
                                                        r_reg.sh[8], r_reg.scl_oe_n);
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) r_reg <= ENG_RST;
    else r_reg <= r_next;
  end

  assign o_done = r_reg.done;
  assign o_rx = r_reg.rx;
  assign o_line_lo = r_reg.line_lo;
  assign o_scl_oe_n = r_reg.scl_oe_n;
  assign o_sda_oe_n = r_reg.sda_oe_n;

endmodule // thi_bit_engine

// file: logic/thi_host_port.sv
// Host-side master for a touch controller object port over I2C.
// Assumes external pull-ups on SCL, SDA and the message-pending line.
`timescale 1ns/100ps
module thi_host_port import thi_pkg::*; #(
  parameter int QTR = QTR_CYCLES,
  parameter logic [7:0] CRC_POLY = CRC_POLY_DEF,
  parameter logic [7:0] CRC_INIT = CRC_INIT_DEF
) (
  input wire logic i_core_clk, // Core clock, 20 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_cmd_valid, // Command offered
  input thi_cmd_s i_cmd, // Command fields
  input wire logic i_wr_valid, // Write byte offered
  input wire logic [7:0] i_wr_data, // Write byte
  input wire logic i_sda_in, // SDA pin level
  input wire logic i_message_pending_n, // Pending pin level
  output logic o_cmd_ready, // Idle, command accepted
  output logic o_wr_ready, // Write byte accepted
  output logic o_done, // Transaction finished pulse
  output logic o_nack_err, // Device refused a byte
  output logic o_rd_valid, // Read byte pulse
  output logic [7:0] o_rd_data, // Read byte
  output logic o_rd_last, // Last byte of the read
  output logic [7:0] o_msg_count, // Count from the last message read
  output logic o_msg_pending, // Synchronised pending level
  output logic o_scl_out, // SCL drive level
  output logic o_scl_oe_n, // SCL enable, low drives
  output logic o_sda_out, // SDA drive level
  output logic o_sda_oe_n // SDA enable, low drives
);

  initial begin
    if (QTR < 2 || QTR > 255) $error("QTR out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_START = 4'b0001,
    S_SLA_W = 4'b0010,
    S_PTR_LO = 4'b0011,
    S_PTR_HI = 4'b0100,
    S_WAIT_DATA = 4'b0101,
    S_DATA = 4'b0110,
    S_CRC = 4'b0111,
    S_STOP = 4'b1000,
    S_SLA_R = 4'b1001,
    S_RCOUNT = 4'b1010,
    S_RBYTE = 4'b1011
  } thi_main_e;

  typedef struct packed {
    thi_main_e st;
    logic pend;
    logic eng_req;
    thi_eng_e eng_op;
    logic [8:0] eng_tx;
    thi_cmd_s cmd;
    logic rd_phase;
    logic dummy;
    logic [15:0] cnt;
    logic [7:0] crc;
    logic [7:0] wbyte;
    logic cmd_ready;
    logic wr_ready;
    logic done;
    logic nack_err;
    logic rd_valid;
    logic [7:0] rd_data;
    logic rd_last;
    logic [7:0] msg_count;
    logic pend_s1;
    logic pend_s2;
    logic pend_out;
    logic sda_s1;
    logic sda_s2;
  } thi_main_s;

  localparam thi_main_s MAIN_RST = '{st: S_IDLE, eng_op: E_IDLE, cmd: '0,
    pend_s1: PIN_IDLE, pend_s2: PIN_IDLE, sda_s1: PIN_IDLE, sda_s2: PIN_IDLE, default: '0};

  thi_main_s r_reg, r_next;
  logic eng_done;
  logic [8:0] eng_rx;
  thi_eng_e op;
  logic [8:0] tx;
  logic eng_state;
  logic dev_nack;

  // Seven-bit device address from the strap setting
  function automatic logic [6:0] dev_addr(logic high);
    return high ? DEV_ADDR_HIGH : DEV_ADDR_LOW;
  endfunction

  // One byte through the CRC, MSB first
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    logic [7:0] v;
    v = c ^ d;
    for (int i = 0; i < 8; i++) v = v[7] ? ({v[6:0], 1'b0} ^ CRC_POLY) : {v[6:0], 1'b0};
    return v;
  endfunction

  // Message bytes to read after the count byte
  function automatic logic [15:0] msg_total(logic [7:0] n, logic [7:0] size, logic crc);
    logic [7:0] per;
    per = (crc || size == 8'h00) ? size : size - 8'h01;
    return 16'(n * per);
  endfunction

  // Transaction sequencer
  always_comb begin
    r_next = r_reg;
    r_next.eng_req = 1'b0;
    r_next.done = 1'b0;
    r_next.rd_valid = 1'b0;
    r_next.rd_last = 1'b0;
    r_next.pend_s1 = i_message_pending_n;
    r_next.pend_s2 = r_reg.pend_s1;
    r_next.pend_out = !r_reg.pend_s2;
    r_next.sda_s1 = i_sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    op = E_BITS;
    tx = {8'hFF, BIT_NACK};
    eng_state = 1'b1;
    dev_nack = eng_rx[0];
    // Bus operation for the current step
    unique case (r_reg.st)
      S_START: op = E_START;
      S_STOP: op = E_STOP;
      S_SLA_W: tx = {dev_addr(r_reg.cmd.addr_high), 1'b0, BIT_NACK};
      S_SLA_R: tx = {dev_addr(r_reg.cmd.addr_high), 1'b1, BIT_NACK};
      S_PTR_LO: tx = {r_reg.cmd.ptr[7:0], BIT_NACK};
      S_PTR_HI: tx = {r_reg.cmd.crc_en && r_reg.cmd.op != OP_READ,
                      r_reg.cmd.ptr[14:8], BIT_NACK};
      S_DATA: tx = {r_reg.wbyte, BIT_NACK};
      S_CRC: tx = {r_reg.crc, BIT_NACK};
      S_RCOUNT: tx = {8'hFF, BIT_ACK};
      S_RBYTE: tx = {8'hFF, (r_reg.cnt == 16'h0001) ? BIT_NACK : BIT_ACK};
      default: eng_state = 1'b0;
    endcase
    if (eng_state && !r_reg.pend) begin
      r_next.eng_req = 1'b1;
      r_next.pend = 1'b1;
      r_next.eng_op = op;
      r_next.eng_tx = tx;
    end
    // Step advance
    if (r_reg.st == S_IDLE) begin
      r_next.cmd_ready = 1'b1;
      if (i_cmd_valid && r_reg.cmd_ready) begin
        r_next.cmd = i_cmd;
        r_next.cmd_ready = 1'b0;
        r_next.nack_err = 1'b0;
        r_next.rd_phase = 1'b0;
        r_next.st = S_START;
      end
    end else if (r_reg.st == S_WAIT_DATA) begin
      if (i_wr_valid && r_reg.wr_ready) begin
        r_next.wbyte = i_wr_data;
        r_next.wr_ready = 1'b0;
        r_next.st = S_DATA;
      end
    end else if (r_reg.pend && eng_done) begin
      r_next.pend = 1'b0;
      unique case (r_reg.st)
        S_START: r_next.st = r_reg.rd_phase ? S_SLA_R : S_SLA_W;
        S_STOP: begin
          if (r_reg.cmd.op != OP_WRITE && !r_reg.rd_phase && !r_reg.nack_err) begin
            r_next.rd_phase = 1'b1;
            r_next.st = S_START;
          end else begin
            r_next.done = 1'b1;
            r_next.st = S_IDLE;
          end
        end
        S_SLA_W, S_PTR_LO, S_PTR_HI, S_DATA, S_CRC, S_SLA_R: begin
          if (dev_nack) begin
            r_next.nack_err = 1'b1;
            r_next.st = S_STOP;
          end else begin
            unique case (r_reg.st)
              S_SLA_W: begin
                r_next.crc = CRC_INIT;
                r_next.st = S_PTR_LO;
              end
              S_PTR_LO: begin
                r_next.crc = crc8(r_reg.crc, r_reg.eng_tx[8:1]);
                r_next.st = S_PTR_HI;
              end
              S_PTR_HI: begin
                r_next.crc = crc8(r_reg.crc, r_reg.eng_tx[8:1]);
                if (r_reg.cmd.op != OP_WRITE) r_next.st = S_STOP;
                else if (r_reg.cmd.len == 8'h00) begin
                  r_next.st = r_reg.cmd.crc_en ? S_CRC : S_STOP;
                end else begin
                  r_next.cnt = {8'h00, r_reg.cmd.len};
                  r_next.wr_ready = 1'b1;
                  r_next.st = S_WAIT_DATA;
                end
              end
              S_DATA: begin
                r_next.crc = crc8(r_reg.crc, r_reg.wbyte);
                r_next.cnt = r_reg.cnt - 16'h0001;
                if (r_reg.cnt == 16'h0001) begin
                  r_next.st = r_reg.cmd.crc_en ? S_CRC : S_STOP;
                end else begin
                  r_next.wr_ready = 1'b1;
                  r_next.st = S_WAIT_DATA;
                end
              end
              S_CRC: r_next.st = S_STOP;
              default: begin
                r_next.dummy = (r_reg.cmd.op == OP_READ) && (r_reg.cmd.len == 8'h00);
                r_next.cnt = (r_reg.cmd.len == 8'h00) ? 16'h0001 : {8'h00, r_reg.cmd.len};
                r_next.st = (r_reg.cmd.op == OP_MSGREAD) ? S_RCOUNT : S_RBYTE;
              end
            endcase
          end
        end
        S_RCOUNT: begin
          r_next.msg_count = eng_rx[8:1];
          if (msg_total(eng_rx[8:1], r_reg.cmd.len, r_reg.cmd.crc_en) == 16'h0000) begin
            r_next.dummy = 1'b1; // Fetches the invalid report and closes
            r_next.cnt = 16'h0001;
          end else begin
            r_next.dummy = 1'b0;
            r_next.cnt = msg_total(eng_rx[8:1], r_reg.cmd.len, r_reg.cmd.crc_en);
          end
          r_next.st = S_RBYTE;
        end
        S_RBYTE: begin
          r_next.rd_valid = !r_reg.dummy;
          r_next.rd_data = eng_rx[8:1];
          r_next.rd_last = (r_reg.cnt == 16'h0001);
          r_next.cnt = r_reg.cnt - 16'h0001;
          if (r_reg.cnt == 16'h0001) r_next.st = S_STOP;
        end
        default: r_next.st = S_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) r_reg <= MAIN_RST;
    else r_reg <= r_next;
  end

  // Bit engine on the shared core clock
  thi_bit_engine #(.QTR(QTR)) u_eng (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_req(r_reg.eng_req),
    .i_op(r_reg.eng_op),
    .i_tx(r_reg.eng_tx),
    .i_sda(r_reg.sda_s2),
    .o_done(eng_done),
    .o_rx(eng_rx),
    .o_line_lo(o_scl_out),
    .o_scl_oe_n(o_scl_oe_n),
    .o_sda_oe_n(o_sda_oe_n)
  );

  // User-side outputs, all registered
  assign o_sda_out = o_scl_out;
  assign o_cmd_ready = r_reg.cmd_ready;
  assign o_wr_ready = r_reg.wr_ready;
  assign o_done = r_reg.done;
  assign o_nack_err = r_reg.nack_err;
  assign o_rd_valid = r_reg.rd_valid;
  assign o_rd_data = r_reg.rd_data;
  assign o_rd_last = r_reg.rd_last;
  assign o_msg_count = r_reg.msg_count;
  assign o_msg_pending = r_reg.pend_out;

  // Checks and coverage
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_sla_write_addr: assert property (r_reg.eng_req && r_reg.st == S_SLA_W |->
    r_reg.eng_tx[8:2] == dev_addr(r_reg.cmd.addr_high) && !r_reg.eng_tx[1])
    else $error("write address byte wrong");
  a_sla_read_bit: assert property (r_reg.eng_req && r_reg.st == S_SLA_R |->
    r_reg.eng_tx[1] && r_reg.eng_tx[8:2] == dev_addr(r_reg.cmd.addr_high))
    else $error("read address byte wrong");
  a_ptr_low_first: assert property (r_reg.eng_req && r_reg.st == S_PTR_LO |->
    r_reg.eng_tx[8:1] == r_reg.cmd.ptr[7:0] && !r_reg.rd_phase)
    else $error("pointer low byte wrong");
  a_ptr_flag_bit: assert property (r_reg.eng_req && r_reg.st == S_PTR_HI |->
    r_reg.eng_tx[8] == (r_reg.cmd.crc_en && r_reg.cmd.op != OP_READ))
    else $error("checksum flag wrong");
  a_crc_byte_last: assert property (r_reg.eng_req && r_reg.st == S_CRC |->
    r_reg.eng_tx[8:1] == r_reg.crc && r_reg.cmd.crc_en ##1 r_reg.st == S_CRC)
    else $error("crc byte wrong");
  a_read_setup_first: assert property (r_reg.st == S_STOP && r_reg.pend && eng_done &&
    r_reg.cmd.op != OP_WRITE && !r_reg.rd_phase && !r_reg.nack_err |=>
    r_reg.st == S_START && r_reg.rd_phase)
    else $error("read without pointer setup");
  a_last_byte_nack: assert property (r_reg.eng_req && r_reg.st == S_RBYTE |->
    r_reg.eng_tx[0] == (r_reg.cnt == 16'h0001))
    else $error("ack bit on read wrong");
  a_count_acked: assert property (r_reg.eng_req && r_reg.st == S_RCOUNT |->
    r_reg.eng_tx[0] == BIT_ACK && r_reg.cmd.op == OP_MSGREAD)
    else $error("count byte not acked");
  a_msg_length: assert property (r_reg.st == S_RCOUNT && r_reg.pend && eng_done &&
    msg_total(eng_rx[8:1], r_reg.cmd.len, r_reg.cmd.crc_en) != 16'h0000 |=>
    r_reg.cnt == msg_total($past(eng_rx[8:1]), r_reg.cmd.len, r_reg.cmd.crc_en))
    else $error("message length wrong");
  a_pending_level: assert property (##3 1'b1 |->
    o_msg_pending == !$past(i_message_pending_n, 3))
    else $error("pending level not tracked");

  c_crc_write: cover property (r_reg.st == S_CRC && eng_done ##[1:200] o_done);
  c_msg_read: cover property (r_reg.st == S_RBYTE && r_reg.rd_last && r_reg.cmd.op == OP_MSGREAD);
  c_nack_err: cover property ($rose(r_reg.nack_err));

endmodule // thi_host_port

// file: bench/thi_dev_model.sv
// Behavioural touch controller object port on the I2C bus, with a message queue.
// Assumes the bench resolves the open-drain wires and pulls them up.
`timescale 1ns/100ps
module thi_dev_model #(
  parameter logic [14:0] CNT_ADR = 15'h0100,
  parameter int MSG_SIZE = 4,
  parameter logic [7:0] POLY = 8'h07,
  parameter logic [7:0] SEED = 8'h00
) (
  input wire logic i_scl, // Bus clock level
  input wire logic i_sda, // Bus data level
  input wire logic i_bus_address_select_pin, // Address strap
  output logic o_sda_oe_n, // SDA enable, low drives
  output logic o_pend_oe_n // Pending enable, low drives
);
  logic [7:0] mem [int];
  logic [7:0] wbuf [$];
  logic [14:0] ptr, rd_start;
  logic [6:0] my_addr;
  logic crc_flag, crc_ok, pend_mode, pend_hold;
  int pend;
  // Pending line held low while any message is unread; mode 0 lets it go mid-read
  assign o_pend_oe_n = (pend == 0) || pend_hold;
  // MSB-first checksum step
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  // Byte k of the message staged while p messages are pending
  function automatic logic [7:0] msg_byte(input int p, input int k, input logic ck);
    logic [7:0] c;
    c = SEED;
    if (ck && k == MSG_SIZE - 1) begin
      for (int j = 0; j < MSG_SIZE - 1; j++) c = crc8(c, msg_byte(p, j, 1'b0));
      return c;
    end
    return (k == 0) ? ((p == 0) ? 8'hFF : 8'(32'h20 + p)) : {p[3:0], 4'(k)};
  endfunction
  // One bit; c is 0 for a bit, 1 for START, 2 for STOP
  task automatic get_bit(output logic b, output int c);
    @(posedge i_scl);
    b = i_sda;
    fork
      @(negedge i_scl);
      @(i_sda);
    join_any
    disable fork;
    c = (i_scl === 1'b0) ? 0 : (i_sda ? 2 : 1);
  endtask
  task automatic rx_byte(output logic [7:0] d, output int c);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b, c);
      d[i] = b;
      if (c != 0) return;
    end
  endtask
  task automatic ack();
    o_sda_oe_n = 1'b0;
    @(negedge i_scl);
    o_sda_oe_n = 1'b1;
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic ak, output int c);
    for (int i = 7; i >= 0; i--) begin
      o_sda_oe_n = d[i];
      @(negedge i_scl);
    end
    o_sda_oe_n = 1'b1;
    get_bit(ak, c);
  endtask
  // One framed transfer after START
  task automatic frame();
    logic [7:0] d, lo, hi, ck;
    logic b, inmsg;
    int c, n, off, mp, msz;
    rx_byte(d, c);
    if (c != 0 || d[7:1] != my_addr) return;
    ack();
    if (d[0] == 1'b0) begin
      wbuf.delete();
      n = 0;
      forever begin
        rx_byte(d, c);
        if (c != 0) break;
        ack();
        if (n == 0) lo = d;
        else if (n == 1) hi = d;
        else wbuf.push_back(d);
        n++;
      end
      if (n < 2) return;
      ptr = {hi[6:0], lo};
      crc_flag = hi[7];
      if (crc_flag && wbuf.size() > 0) begin
        ck = crc8(crc8(SEED, lo), hi);
        for (int i = 0; i < wbuf.size() - 1; i++) ck = crc8(ck, wbuf[i]);
        crc_ok = (ck == wbuf.pop_back());
      end
      foreach (wbuf[i]) mem[ptr + i] = wbuf[i];
      return;
    end
    rd_start = ptr;
    inmsg = 1'b0;
    off = 0;
    mp = 0;
    msz = crc_flag ? MSG_SIZE : MSG_SIZE - 1;
    forever begin
      if (inmsg && off == 0) mp = pend;
      if (inmsg) d = msg_byte(mp, off, crc_flag);
      else if (ptr == CNT_ADR) d = 8'(pend);
      else d = mem[ptr];
      tx_byte(d, b, c);
      if (c != 0 || b) break;
      if (inmsg && off == 0 && pend > 0) pend--;
      if (inmsg && off == 0 && !pend_mode) pend_hold = 1'b1;
      if (inmsg) off = (off + 1 == msz) ? 0 : off + 1;
      else if (ptr == CNT_ADR) inmsg = 1'b1;
      else ptr++;
    end
    ptr = inmsg ? CNT_ADR : rd_start;
  endtask
  // Strap sampled once at start-up, then serve frames
  initial begin
    o_sda_oe_n = 1'b1;
    pend = 0;
    crc_ok = 1'b0;
    crc_flag = 1'b0;
    pend_mode = 1'b1;
    pend_hold = 1'b0;
    ptr = '0;
    #1;
    my_addr = i_bus_address_select_pin ? 7'h4B : 7'h4A;
    forever begin
      @(negedge i_sda iff i_scl === 1'b1);
      frame();
      // Mode 0 keeps the line released until the STOP that ends the read
      if (pend_hold) @(posedge i_sda iff i_scl === 1'b1);
      pend_hold = 1'b0;
    end
  end
endmodule // thi_dev_model

// file: bench/thi_host_port_tb.sv
// Self-checking bench for the object port master against the device model.
// Assumes the design package and the device model are compiled first.
`timescale 1ns/100ps
module thi_host_port_tb import thi_pkg::*; ;
  localparam int MSZ = 4;
  localparam logic [14:0] CNT = 15'h0100;
  logic clk, rst_n, cmd_valid, wr_valid, dev_sda_oe_n, dev_pend_oe_n;
  thi_cmd_s cmd;
  logic [7:0] wr_data, rd_data, msg_count;
  logic cmd_ready, wr_ready, done, nack_err, rd_valid, rd_last, msg_pending;
  logic scl_oe_n, sda_oe_n, scl_out, sda_out;
  wire scl_w, sda_w;
  logic [7:0] wq [$];
  logic [8:0] exp_q [$];
  logic [31:0] rs;
  int bad_count, num_checks;
  // Open-drain wires with pull-ups
  assign scl_w = scl_oe_n | scl_out;
  assign sda_w = (sda_oe_n | sda_out) & dev_sda_oe_n;
  thi_host_port #(.QTR(4)) i_thi_host_port (.i_core_clk(clk), .i_resetn(rst_n),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
    .i_sda_in(sda_w), .i_message_pending_n(dev_pend_oe_n), .o_cmd_ready(cmd_ready),
    .o_wr_ready(wr_ready), .o_done(done), .o_nack_err(nack_err), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_rd_last(rd_last), .o_msg_count(msg_count),
    .o_msg_pending(msg_pending), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n),
    .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n));
  thi_dev_model #(.CNT_ADR(CNT), .MSG_SIZE(MSZ)) i_thi_dev_model (.i_scl(scl_w),
    .i_sda(sda_w), .i_bus_address_select_pin(1'b0), .o_sda_oe_n(dev_sda_oe_n),
    .o_pend_oe_n(dev_pend_oe_n));
  // Core clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Offer one command, wait for its completion pulse
  task automatic run_cmd(input thi_op_e o, input logic [14:0] p, input logic ce,
                         input logic [7:0] n, input logic ah, input logic en);
    int t;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{op: o, ptr: p, crc_en: ce, len: n, addr_high: ah};
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (cmd_ready !== 1'b1 && t < 100);
    #1;
    cmd_valid = 1'b0;
    for (t = 0; t < 20000 && done !== 1'b1; t++) @(posedge clk);
    chk(done === 1'b1 && nack_err === en && exp_q.size() == 0, "transaction end");
  endtask
  // Write byte feeder: each byte held until the design takes it
  initial begin
    wr_valid = 1'b0;
    wr_data = 8'h00;
    forever begin
      @(posedge clk);
      if (wr_valid && wr_ready === 1'b1) void'(wq.pop_front());
      #1;
      wr_valid = (wq.size() != 0);
      wr_data = (wq.size() != 0) ? wq[0] : 8'h00;
    end
  end
  // Read byte monitor against the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected read byte");
      else chk({rd_last, rd_data} === exp_q.pop_front(), "read byte wrong");
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    chk(1'b0, "timeout");
    close_out();
  end
  // Main sequence
  initial begin
    logic [14:0] p;
    logic [8:0] dq [$];
    int n;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    bad_count = 0;
    num_checks = 0;
    rs = 32'hEFFFAFDC;
    repeat (16) @(posedge clk);
    chk(cmd_ready === 1'b0 && scl_oe_n === 1'b1 && sda_oe_n === 1'b1, "reset state");
    #1;
    rst_n = 1'b1;
    // Plain then checksummed write, each read back
    for (int k = 0; k < 2; k++) begin
      rs = xs(rs);
      p = {1'b1, rs[13:0]};
      for (int i = 0; i < 4 - 2 * k; i++) begin
        rs = xs(rs);
        wq.push_back(rs[7:0]);
        dq.push_back({i == 3 - 2 * k, rs[7:0]});
      end
      i_thi_dev_model.crc_ok = 1'b0;
      run_cmd(OP_WRITE, p, k[0], 8'(4 - 2 * k), 1'b0, 1'b0);
      if (k == 1) chk(i_thi_dev_model.crc_ok === 1'b1, "write checksum");
      // Read-back notes only after the write has closed
      exp_q = dq;
      dq.delete();
      run_cmd(OP_READ, p, 1'b0, 8'(4 - 2 * k), 1'b0, 1'b0);
    end
    // Other bus address is not answered
    run_cmd(OP_READ, p, 1'b0, 8'h01, 1'b1, 1'b1);
    // Message reads: three plain, two checksummed, none pending
    for (int m = 0; m < 3; m++) begin
      n = (m == 2) ? 0 : 3 - m;
      #1;
      i_thi_dev_model.pend_mode = (m != 0);
      i_thi_dev_model.pend = n;
      repeat (10) @(posedge clk);
      chk(msg_pending === (n != 0), "pending level");
      for (int q = n; q > 0; q--) begin
        for (int j = 0; j < MSZ - (m != 1); j++) begin
          exp_q.push_back({q == 1 && j == MSZ - 1 - (m != 1),
                           i_thi_dev_model.msg_byte(q, j, m == 1)});
        end
      end
      // Mode 0 releases after the first message byte, mode 1 holds while more follow
      if (n != 0) fork
        begin
          @(posedge clk iff rd_valid === 1'b1);
          repeat (8) @(posedge clk);
          chk(msg_pending === (m != 0), "pending mode");
        end
      join_none
      run_cmd(OP_MSGREAD, CNT, m == 1, 8'(MSZ), 1'b0, 1'b0);
      repeat (10) @(posedge clk);
      chk(msg_count === 8'(n) && msg_pending === 1'b0, "message count");
    end
    close_out();
  end
endmodule // thi_host_port_tb
